//--- core/cfcs_pkg.sv
// Package of register offsets, bit positions and sizes for the channel control/status block
package cfcs_pkg;
    // Register offsets relative to channel base
    localparam logic [3:0] CFCS_OFF_CONTROL = 4'h0;
    localparam logic [3:0] CFCS_OFF_STATUS  = 4'h4;
    // Control bit positions
    localparam int CTL_TX_FIFO_RST   = 0;
    localparam int CTL_RX_FIFO_RST   = 1;
    localparam int CTL_BYPASS        = 2;
    localparam int CTL_CHAN_IRQ_EN   = 3;
    localparam int CTL_FORCE_IRQ     = 4;
    localparam int CTL_WR_DMA_IRQ_EN = 5;
    localparam int CTL_RD_DMA_IRQ_EN = 6;
    localparam int CTL_TX_BOOST      = 7;
    localparam int CTL_RX_BOOST      = 8;
    localparam int CTL_INIT_MEM      = 16;
    localparam int CTL_TX_MOVER_EN   = 17;
    localparam int CTL_RX_MOVER_EN   = 18;
    localparam logic [31:0] CTL_WRITE_MASK  = 32'h0007_01FF;
    localparam logic [31:0] CTL_RESET_VALUE = 32'h0000_0000;
    // Status bit positions
    localparam int ST_TX_AEMPTY      = 1;
    localparam int ST_TX_FULL        = 2;
    localparam int ST_RX_EMPTY       = 4;
    localparam int ST_RX_AFULL       = 5;
    localparam int ST_RX_FULL        = 6;
    localparam int ST_TX_LOW_IRQ     = 8;
    localparam int ST_RX_HIGH_IRQ    = 9;
    localparam int ST_TX_LOW_LAT     = 10;
    localparam int ST_RX_HIGH_LAT    = 11;
    localparam int ST_WR_DMA_ERR     = 12;
    localparam int ST_RD_DMA_ERR     = 13;
    localparam int ST_WR_DMA_DONE    = 14;
    localparam int ST_RD_DMA_DONE    = 15;
    localparam int ST_TX_COMPLETE    = 16;
    localparam int ST_RX_RETX_DONE   = 17;
    localparam int ST_TX_RETX_DONE   = 18;
    localparam int ST_RX_OVERFLOW    = 19;
    localparam int ST_RX_SM_IDLE     = 20;
    localparam int ST_TX_SM_IDLE     = 21;
    localparam int ST_C2H_DMA_IDLE   = 22;
    localparam int ST_H2C_DMA_IDLE   = 23;
    localparam int ST_LOCAL_IRQ      = 30;
    localparam int ST_IRQ_STATUS     = 31;
    // Sticky latch group cleared by write-one
    localparam logic [31:0] ST_W1C_MASK = 32'h000F_FC00;
    // Storage sizes
    localparam int CFCS_FIFO_DEPTH   = 512;
    localparam int CFCS_WORD_BITS    = 32;
    localparam int CFCS_MEM_WORDS    = 8388608;
    localparam int CFCS_LEVEL_BITS   = 24;
    // Memory init sequence length in clocks
    localparam int CFCS_INIT_CYCLES  = 16;
endpackage : cfcs_pkg

//--- core/cfcs_fifo.sv
// Word FIFO with registered read data used for each storage stage
`timescale 1ns/1ps
module cfcs_fifo
    import cfcs_pkg::*;
#(
    parameter int WIDTH = CFCS_WORD_BITS,
    parameter int DEPTH = CFCS_FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  empty,
    output logic                  full,
    output logic      [AW:0]      count
);
    typedef struct packed {
        logic [AW-1:0]    wp;
        logic [AW-1:0]    rp;
        logic [AW:0]      cnt;
        logic [WIDTH-1:0] dout;
    } cfcs_fifo_state_t;

    logic [WIDTH-1:0]  mem_reg [DEPTH];
    cfcs_fifo_state_t  st_reg;
    cfcs_fifo_state_t  st_next;
    logic              do_wr;
    logic              do_rd;

    // Guarded strobes; a write when full is dropped
    assign do_wr = wr_en && (st_reg.cnt != DEPTH[AW:0]);
    assign do_rd = rd_en && (st_reg.cnt != '0);

    // ---------------------------------------------------------------
    // Pointer and count update
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (do_wr) begin
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (do_rd) begin
            st_next.rp   = st_reg.rp + 1'b1;
            st_next.dout = mem_reg[st_reg.rp];
        end
        st_next.cnt = st_reg.cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        if (clear) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage array has no reset, keeps it a plain RAM
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_reg[st_reg.wp] <= wr_data;
        end
    end

    assign rd_data = st_reg.dout;
    assign empty   = (st_reg.cnt == '0);
    assign full    = (st_reg.cnt == DEPTH[AW:0]);
    assign count   = st_reg.cnt;
endmodule : cfcs_fifo

//--- core/cfcs_channel.sv
// Channel control and status registers with FIFO chain, loop-back mover and memory-init sequencing
`timescale 1ns/1ps
module cfcs_channel
    import cfcs_pkg::*;
#(
    parameter int DEPTH      = CFCS_FIFO_DEPTH,
    parameter int LVL_BITS   = CFCS_LEVEL_BITS,
    parameter int INIT_COUNT = CFCS_INIT_CYCLES
) (
    input  wire logic                SYS_CLK,
    input  wire logic                RST_N,
    // Register port
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    input  wire logic [3:0]          REG_ADDR,
    input  wire logic [31:0]         REG_WDATA,
    output logic      [31:0]         REG_RDATA,
    // Host side transmit write and receive read
    input  wire logic                TX_WR,
    input  wire logic [31:0]         TX_WDATA,
    output logic                     TX_WREADY,
    input  wire logic                RX_RD,
    output logic      [31:0]         RX_RDATA,
    output logic                     RX_RVALID,
    // I/O side transmit read and receive write
    input  wire logic                IO_TX_RD,
    output logic      [31:0]         IO_TX_RDATA,
    output logic                     IO_TX_AVAIL,
    input  wire logic                IO_RX_WR,
    input  wire logic [31:0]         IO_RX_WDATA,
    // Functions and levels
    input  wire logic                TX_FUNC_EN,
    input  wire logic                RX_FUNC_EN,
    input  wire logic [LVL_BITS-1:0] TX_LOW_LEVEL,
    input  wire logic [LVL_BITS-1:0] RX_HIGH_LEVEL,
    input  wire logic [31:0]         RX_MEMORY_SECTION,
    // Events from DMA engines and state machines
    input  wire logic                WR_DMA_DONE,
    input  wire logic                RD_DMA_DONE,
    input  wire logic                WR_DMA_ERR,
    input  wire logic                RD_DMA_ERR,
    input  wire logic                TX_XFER_DONE,
    input  wire logic                TX_RETX_DONE,
    input  wire logic                RX_RETX_DONE,
    input  wire logic                HOST_TO_CARD_DMA_IDLE,
    input  wire logic                CARD_TO_HOST_DMA_IDLE,
    input  wire logic                TRANSMIT_SM_IDLE,
    input  wire logic                RECEIVE_SM_IDLE,
    input  wire logic                TX_LOW_IRQ_EN,
    input  wire logic                RX_HIGH_IRQ_EN,
    input  wire logic                TX_COMPLETE_IRQ_EN,
    input  wire logic                MEM_INIT_DONE,
    // Outputs
    output logic                     HOST_IRQ,
    output logic                     TX_DMA_PRIORITY_BOOST,
    output logic                     RX_DMA_PRIORITY_BOOST,
    output logic                     SM_RESET,
    output logic                     MEM_INIT_START,
    output logic      [31:0]         MEM_INIT_PARAMS,
    output logic                     MEM_BYPASS
);
    localparam int AW = $clog2(DEPTH);

    typedef enum logic [1:0] {CFCS_MEM_IDLE, CFCS_MEM_INIT, CFCS_MEM_RUN} cfcs_mem_t;

    typedef struct packed {
        logic [31:0]  ctrl;
        logic [31:0]  latch;
        logic [31:0]  rdata;
        logic [31:0]  params;
        cfcs_mem_t    mem;
        logic [15:0]  init_cnt;
        logic         init_start;
        logic         tx_lvl_prev;
        logic         rx_lvl_prev;
    } cfcs_state_t;

    cfcs_state_t st_reg;
    cfcs_state_t st_next;

    // FIFO interconnect
    logic [31:0]  hd_tx_q, io_tx_q, io_rx_q, hd_rx_q;
    logic         hd_tx_e, hd_tx_f, io_tx_e, io_tx_f;
    logic         io_rx_e, io_rx_f, hd_rx_e, hd_rx_f;
    logic [AW:0]  hd_tx_c, io_tx_c, io_rx_c, hd_rx_c;
    logic         tx_clr, rx_clr;
    logic         tx_move, rx_move, loop_move;
    logic         loop_en;
    logic         tx_mv_pend_reg, rx_mv_pend_reg, loop_pend_reg;
    logic         hd_tx_rd, io_tx_wr, io_rx_rd, hd_rx_wr;
    logic [31:0]  io_tx_wd, hd_rx_wd;
    logic         io_rx_wr_int;
    logic [LVL_BITS-1:0] tx_level, rx_level;
    logic         tx_low, rx_high;
    logic         local_irq, dma_irq;
    logic [31:0]  status;
    logic         rx_ovf_evt;

    // ---------------------------------------------------------------
    // FIFO resets and state-machine hold
    // ---------------------------------------------------------------
    // per-direction clear
    assign tx_clr   = st_reg.ctrl[CTL_TX_FIFO_RST];
    assign rx_clr   = st_reg.ctrl[CTL_RX_FIFO_RST];
    assign SM_RESET = tx_clr | rx_clr;

    assign loop_en = st_reg.ctrl[CTL_BYPASS] && !TX_FUNC_EN && !RX_FUNC_EN;
    assign MEM_BYPASS = st_reg.ctrl[CTL_BYPASS];
    // Loop-back and the I/O partner never load the receive stage together

    // ---------------------------------------------------------------
    // Movers: host FIFO to I/O FIFO on transmit, I/O FIFO to host FIFO on receive, plus loop-back
    // ---------------------------------------------------------------
    // bypass movers need their enable; the memory path runs on its own
    // The memory path is modelled as a direct hop, so only the latency differs
    // Receive mover also drains loop-back words so they reach the host side
    assign tx_move   = (st_reg.ctrl[CTL_TX_MOVER_EN] || !st_reg.ctrl[CTL_BYPASS])
                       && !hd_tx_e && !io_tx_f && !tx_mv_pend_reg && !tx_clr;
    assign rx_move   = (st_reg.ctrl[CTL_RX_MOVER_EN] || !st_reg.ctrl[CTL_BYPASS])
                       && !io_rx_e && !hd_rx_f && !rx_mv_pend_reg && !rx_clr;
    // loop-back from transmit stage to receive stage
    assign loop_move = loop_en && !io_tx_e && !io_rx_f && !loop_pend_reg && !tx_clr && !rx_clr;

    // Read data lands one cycle after the pop, so writes trail by one
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            tx_mv_pend_reg <= 1'b0;
            rx_mv_pend_reg <= 1'b0;
            loop_pend_reg  <= 1'b0;
        end else begin
            tx_mv_pend_reg <= tx_move;
            rx_mv_pend_reg <= rx_move;
            loop_pend_reg  <= loop_move;
        end
    end

    assign hd_tx_rd     = tx_move;
    assign io_tx_wr     = tx_mv_pend_reg;
    assign io_tx_wd     = hd_tx_q;
    assign io_rx_wr_int = loop_pend_reg ? 1'b1 : (IO_RX_WR && !loop_en);
    assign io_rx_rd     = rx_move;
    assign hd_rx_wr     = rx_mv_pend_reg;
    assign hd_rx_wd     = io_rx_q;
    // Overflow when a loader hits a full receive stage
    assign rx_ovf_evt   = IO_RX_WR && !loop_en && io_rx_f;

    // four 512-word stages; bypass chains two per direction
    // Both stages of a direction share one clear so a reset empties the chain
    cfcs_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_host_tx (
        .clk(SYS_CLK), .rst_n(RST_N), .clear(tx_clr), .wr_en(TX_WR), .wr_data(TX_WDATA),
        .rd_en(hd_tx_rd), .rd_data(hd_tx_q), .empty(hd_tx_e), .full(hd_tx_f), .count(hd_tx_c));
    cfcs_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_io_tx (
        .clk(SYS_CLK), .rst_n(RST_N), .clear(tx_clr), .wr_en(io_tx_wr), .wr_data(io_tx_wd),
        .rd_en(IO_TX_RD || loop_move), .rd_data(io_tx_q), .empty(io_tx_e), .full(io_tx_f), .count(io_tx_c));
    cfcs_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_io_rx (
        .clk(SYS_CLK), .rst_n(RST_N), .clear(rx_clr), .wr_en(io_rx_wr_int),
        .wr_data(loop_pend_reg ? io_tx_q : IO_RX_WDATA),
        .rd_en(io_rx_rd), .rd_data(io_rx_q), .empty(io_rx_e), .full(io_rx_f), .count(io_rx_c));
    cfcs_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_host_rx (
        .clk(SYS_CLK), .rst_n(RST_N), .clear(rx_clr), .wr_en(hd_rx_wr), .wr_data(hd_rx_wd),
        .rd_en(RX_RD), .rd_data(hd_rx_q), .empty(hd_rx_e), .full(hd_rx_f), .count(hd_rx_c));

    // Host-side handshakes are combinational from the FIFO flags
    assign TX_WREADY   = !hd_tx_f;
    assign RX_RDATA    = hd_rx_q;
    assign RX_RVALID   = !hd_rx_e;
    assign IO_TX_RDATA = io_tx_q;
    assign IO_TX_AVAIL = !io_tx_e;

    // ---------------------------------------------------------------
    // Chain levels and almost flags
    // ---------------------------------------------------------------
    // level over whole chain per direction
    // Limitation: levels ignore a word still in flight inside a mover
    assign tx_level = LVL_BITS'(hd_tx_c) + LVL_BITS'(io_tx_c);
    assign rx_level = LVL_BITS'(io_rx_c) + LVL_BITS'(hd_rx_c);
    // Almost-full is strictly above the level, almost-empty at or below
    assign tx_low   = (tx_level <= TX_LOW_LEVEL);
    assign rx_high  = (rx_level >  RX_HIGH_LEVEL);

    assign TX_DMA_PRIORITY_BOOST = st_reg.ctrl[CTL_TX_BOOST] && tx_low;
    assign RX_DMA_PRIORITY_BOOST = st_reg.ctrl[CTL_RX_BOOST] && rx_high;

    // ---------------------------------------------------------------
    // Interrupt combination
    // ---------------------------------------------------------------
    // local sources masked by their own enables, force included
    assign local_irq = (st_reg.latch[ST_TX_LOW_LAT] && TX_LOW_IRQ_EN)
                     || (st_reg.latch[ST_RX_HIGH_LAT] && RX_HIGH_IRQ_EN)
                     || (st_reg.latch[ST_TX_COMPLETE] && TX_COMPLETE_IRQ_EN)
                     || st_reg.ctrl[CTL_FORCE_IRQ];
    assign dma_irq   = (st_reg.latch[ST_WR_DMA_DONE] && st_reg.ctrl[CTL_WR_DMA_IRQ_EN])
                     || (st_reg.latch[ST_RD_DMA_DONE] && st_reg.ctrl[CTL_RD_DMA_IRQ_EN]);
    // force and local only pass with channel enable
    assign HOST_IRQ  = dma_irq || (local_irq && st_reg.ctrl[CTL_CHAN_IRQ_EN]);

    // ---------------------------------------------------------------
    // Status word assembly
    // ---------------------------------------------------------------
    always_comb begin
        status = st_reg.latch & ST_W1C_MASK;
        status[ST_IRQ_STATUS]   = HOST_IRQ;
        status[ST_LOCAL_IRQ]    = local_irq;
        status[ST_H2C_DMA_IDLE] = HOST_TO_CARD_DMA_IDLE;
        status[ST_C2H_DMA_IDLE] = CARD_TO_HOST_DMA_IDLE;
        status[ST_TX_SM_IDLE]   = TRANSMIT_SM_IDLE;
        status[ST_RX_SM_IDLE]   = RECEIVE_SM_IDLE;
        status[ST_RX_HIGH_IRQ]  = st_reg.latch[ST_RX_HIGH_LAT] && RX_HIGH_IRQ_EN;
        status[ST_TX_LOW_IRQ]   = st_reg.latch[ST_TX_LOW_LAT] && TX_LOW_IRQ_EN;
        status[ST_RX_FULL]      = hd_rx_f;
        status[ST_RX_AFULL]     = rx_high;
        status[ST_RX_EMPTY]     = hd_rx_e;
        // transmit flags, bit 3 left zero
        status[ST_TX_FULL]      = hd_tx_f;
        status[ST_TX_AEMPTY]    = tx_low;
        status[0]               = hd_tx_e;
    end

    // ---------------------------------------------------------------
    // Register state update
    // ---------------------------------------------------------------
    always_comb begin
        logic [31:0] set_ev;
        logic [31:0] clr_ev;
        set_ev = '0;
        clr_ev = '0;
        st_next = st_reg;
        st_next.init_start  = 1'b0;
        st_next.tx_lvl_prev = tx_low;
        st_next.rx_lvl_prev = rx_high;
        // Control writes; unused bits masked
        if (REG_WR && REG_ADDR == CFCS_OFF_CONTROL) begin
            st_next.ctrl = (REG_WDATA & CTL_WRITE_MASK) | (st_reg.ctrl & ~CTL_WRITE_MASK);
            // init bit ignored unless controller is idle
            // The write mask covers this bit, so restore it when busy
            if (st_reg.mem == CFCS_MEM_IDLE) begin
                st_next.ctrl[CTL_INIT_MEM] = REG_WDATA[CTL_INIT_MEM];
            end else begin
                st_next.ctrl[CTL_INIT_MEM] = st_reg.ctrl[CTL_INIT_MEM];
            end
        end
        set_ev[ST_WR_DMA_DONE]  = WR_DMA_DONE;
        set_ev[ST_RD_DMA_DONE]  = RD_DMA_DONE;
        set_ev[ST_WR_DMA_ERR]   = WR_DMA_ERR;
        set_ev[ST_RD_DMA_ERR]   = RD_DMA_ERR;
        set_ev[ST_TX_COMPLETE]  = TX_XFER_DONE;
        set_ev[ST_TX_RETX_DONE] = TX_RETX_DONE;
        set_ev[ST_RX_RETX_DONE] = RX_RETX_DONE;
        set_ev[ST_RX_OVERFLOW]  = rx_ovf_evt;
        set_ev[ST_RX_HIGH_LAT]  = rx_high && !st_reg.rx_lvl_prev;
        set_ev[ST_TX_LOW_LAT]   = tx_low && !st_reg.tx_lvl_prev;
        if (REG_WR && REG_ADDR == CFCS_OFF_STATUS) begin
            clr_ev = REG_WDATA & ST_W1C_MASK;
        end
        // write-one clear, a same-cycle event wins
        st_next.latch = ((st_reg.latch & ~clr_ev) | set_ev) & ST_W1C_MASK;
        // Memory controller sequencing
        unique case (st_reg.mem)
            CFCS_MEM_IDLE: begin
                // start and sample the section parameters
                if (st_reg.ctrl[CTL_INIT_MEM]) begin
                    st_next.params     = RX_MEMORY_SECTION;
                    st_next.init_start = 1'b1;
                    st_next.init_cnt   = '0;
                    st_next.mem        = CFCS_MEM_INIT;
                end
            end
            CFCS_MEM_INIT: begin
                st_next.init_cnt = st_reg.init_cnt + 16'h0001;
                if (MEM_INIT_DONE || st_reg.init_cnt == 16'(INIT_COUNT - 1)) begin
                    st_next.ctrl[CTL_INIT_MEM] = 1'b0;
                    st_next.mem                = CFCS_MEM_RUN;
                end
            end
            CFCS_MEM_RUN: begin
                // FIFO reset returns controller to idle
                if (tx_clr || rx_clr) begin
                    st_next.mem = CFCS_MEM_IDLE;
                end
            end
            // Unused code falls back to idle rather than locking up
            default: begin
                st_next.mem = CFCS_MEM_IDLE;
            end
        endcase
        // Read data registered on the strobe
        if (REG_RD) begin
            st_next.rdata = (REG_ADDR == CFCS_OFF_CONTROL) ? st_reg.ctrl :
                            (REG_ADDR == CFCS_OFF_STATUS)  ? status : 32'h0000_0000;
        end
    end

    // Single register stage for all register and sequencer state keeps the update in one place
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_reg      <= '0;
            st_reg.ctrl <= CTL_RESET_VALUE;
            st_reg.mem  <= CFCS_MEM_IDLE;
            // An empty chain is already low, so no false low-level latch after reset
            st_reg.tx_lvl_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // large storage path is external; parameters handed over here
    assign REG_RDATA       = st_reg.rdata;
    assign MEM_INIT_START  = st_reg.init_start;
    assign MEM_INIT_PARAMS = st_reg.params;
endmodule : cfcs_channel

//--- testbench/cfcs_channel_checker.sv
// Assertion checker for the channel control and status block
`timescale 1ns/1ps
module cfcs_channel_checker
    import cfcs_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic        RD_DMA_DONE,
    input wire logic        HOST_IRQ,
    input wire logic        TX_DMA_PRIORITY_BOOST,
    input wire logic        RX_DMA_PRIORITY_BOOST,
    input wire logic        SM_RESET,
    input wire logic        MEM_INIT_START,
    input wire logic [31:0] MEM_INIT_PARAMS,
    input wire logic [31:0] RX_MEMORY_SECTION,
    input wire logic        MEM_BYPASS
);
    logic [31:0] ctl_reg;
    wire         cw = REG_WR && REG_ADDR == CFCS_OFF_CONTROL;
    // Shadow of control bits; init bit copied as written although the design self-clears it
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) ctl_reg <= 32'h0;
        else if (cw) ctl_reg <= REG_WDATA & CTL_WRITE_MASK;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_reset_hold: assert property (cw |=> SM_RESET == |$past(REG_WDATA[1:0]))
        else $error("state machine reset wrong");
    a_bypass_sel: assert property (cw |=> MEM_BYPASS == $past(REG_WDATA[2]))
        else $error("bypass select wrong");
    a_init_pulse: assert property (MEM_INIT_START |=> !MEM_INIT_START)
        else $error("init start not one pulse");
    a_init_params: assert property (MEM_INIT_START |-> MEM_INIT_PARAMS == RX_MEMORY_SECTION)
        else $error("init parameters wrong");
    a_unmapped_zero: assert property (REG_RD && REG_ADDR == 4'h8 |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_tx_boost: assert property (TX_DMA_PRIORITY_BOOST |-> ctl_reg[CTL_TX_BOOST])
        else $error("transmit boost without enable");
    a_rx_boost: assert property (RX_DMA_PRIORITY_BOOST |-> ctl_reg[CTL_RX_BOOST])
        else $error("receive boost without enable");
    a_force_irq: assert property (ctl_reg[CTL_FORCE_IRQ] && ctl_reg[CTL_CHAN_IRQ_EN] |-> HOST_IRQ)
        else $error("forced interrupt missing");
    a_dma_irq: assert property (RD_DMA_DONE && ctl_reg[CTL_RD_DMA_IRQ_EN] |=> HOST_IRQ)
        else $error("read DMA interrupt missing");
    a_irq_quiet: assert property (ctl_reg[6:3] == 4'h0 |-> !HOST_IRQ)
        else $error("interrupt while all enables off");
    c_init: cover property (MEM_INIT_START);
    c_irq: cover property (HOST_IRQ);
    c_boost: cover property (TX_DMA_PRIORITY_BOOST);
endmodule : cfcs_channel_checker
bind cfcs_channel cfcs_channel_checker u_chk (.*);

//--- testbench/cfcs_io_partner.sv
// I/O side partner: loops transmit words back into the receive FIFO
`timescale 1ns/1ps
module cfcs_io_partner (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic        avail,
    input  wire logic [31:0] rdata,
    output logic             rd,
    output logic             wr,
    output logic [31:0]      wdata,
    output logic             sm_idle
);
    logic rd_d;
    assign sm_idle = !run;
    // One word per three clocks so the empty flag is seen settled
    always @(posedge clk) begin
        if (!rst_n) begin
            rd <= 1'b0;
            rd_d <= 1'b0;
            wr <= 1'b0;
            wdata <= 32'h0;
        end else begin
            rd <= run && avail && !rd && !rd_d;
            rd_d <= rd;
            wr <= rd_d;
            wdata <= rd_d ? rdata : ~wdata;
        end
    end
endmodule : cfcs_io_partner

//--- testbench/cfcs_channel_bench.sv
// Self-checking bench for the channel control and status block
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module cfcs_channel_bench
    import cfcs_pkg::*;
;
    localparam int INIT_N = 8;
    int cmp_count = 0, failures = 0;
    logic SYS_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, TX_WR = 0, RX_RD = 0, rd_d = 0, rx_d = 0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [6:0] ev = 7'h0;
    logic [31:0] REG_WDATA = 0, TX_WDATA = 0, RX_MEMORY_SECTION = 0, REG_RDATA, RX_RDATA, IO_TX_RDATA;
    logic [31:0] IO_RX_WDATA, MEM_INIT_PARAMS, w, e_v, m_v;
    logic TX_FUNC_EN = 0, RX_FUNC_EN = 0, HOST_TO_CARD_DMA_IDLE, CARD_TO_HOST_DMA_IDLE, MEM_INIT_DONE = 0;
    logic TX_LOW_IRQ_EN, RX_HIGH_IRQ_EN, TX_COMPLETE_IRQ_EN, TX_WREADY, RX_RVALID, IO_TX_RD, IO_TX_AVAIL;
    logic IO_RX_WR, TRANSMIT_SM_IDLE, RECEIVE_SM_IDLE, HOST_IRQ, TX_DMA_PRIORITY_BOOST, RX_DMA_PRIORITY_BOOST;
    logic SM_RESET, MEM_INIT_START, MEM_BYPASS;
    logic [23:0] TX_LOW_LEVEL = 24'h0, RX_HIGH_LEVEL = 24'hFFFFFF;
    logic [31:0] exp_q[$], msk_q[$], rx_q[$];
    int bp[7] = '{ST_WR_DMA_DONE, ST_RD_DMA_DONE, ST_WR_DMA_ERR, ST_RD_DMA_ERR, ST_TX_COMPLETE, ST_TX_RETX_DONE,
                  ST_RX_RETX_DONE};
    assign RECEIVE_SM_IDLE = TRANSMIT_SM_IDLE;
    cfcs_channel #(.INIT_COUNT(INIT_N)) uut (.*, .WR_DMA_DONE(ev[0]), .RD_DMA_DONE(ev[1]), .WR_DMA_ERR(ev[2]),
        .RD_DMA_ERR(ev[3]), .TX_XFER_DONE(ev[4]), .TX_RETX_DONE(ev[5]), .RX_RETX_DONE(ev[6]));
    cfcs_io_partner mdl (.clk(SYS_CLK), .rst_n(RST_N), .run(TX_FUNC_EN), .avail(IO_TX_AVAIL), .rdata(IO_TX_RDATA),
        .rd(IO_TX_RD), .wr(IO_RX_WR), .wdata(IO_RX_WDATA), .sm_idle(TRANSMIT_SM_IDLE));
    initial forever #10 SYS_CLK = ~SYS_CLK;
    // Read data lands one clock after the strobe; oldest note is compared
    always @(posedge SYS_CLK) begin
        if (rd_d) begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            `CHK("reg read", e_v, REG_RDATA & m_v)
        end
        if (rx_d) begin
            e_v = rx_q.pop_front();
            `CHK("rx word", e_v, RX_RDATA)
        end
        rd_d <= REG_RD;
        rx_d <= RX_RD;
    end
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge SYS_CLK) begin REG_WR <= 1; REG_ADDR <= a; REG_WDATA <= d; end
        @(posedge SYS_CLK) REG_WR <= 0;
        // Return off the edge so callers see the written state settled
        @(negedge SYS_CLK);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge SYS_CLK) begin REG_RD <= 1; REG_ADDR <= a; exp_q.push_back(e & m); msk_q.push_back(m); end
        @(posedge SYS_CLK) REG_RD <= 0;
    endtask : rd
    // Push random words, then pop them back one at a time
    task automatic traffic(input int n);
        int k;
        logic [31:0] v;
        for (int i = 0; i < n; i++) begin
            v = $urandom;
            rx_q.push_back(v);
            @(posedge SYS_CLK) begin TX_WR <= 1; TX_WDATA <= v; end
            @(posedge SYS_CLK) TX_WR <= 0;
        end
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin @(negedge SYS_CLK); k++; end while (RX_RVALID !== 1'b1 && k < 300);
            if (k >= 300) begin failures++; end_of_test(); end
            `CHK("rx boost", RX_HIGH_LEVEL == 24'h0, RX_DMA_PRIORITY_BOOST)
            `CHK("tx ready", 1'b1, TX_WREADY)
            @(posedge SYS_CLK) RX_RD <= 1;
            @(posedge SYS_CLK) RX_RD <= 0;
        end
    endtask : traffic
    initial begin
        void'($urandom(22));
        {TX_LOW_IRQ_EN, RX_HIGH_IRQ_EN, TX_COMPLETE_IRQ_EN} = 3'($urandom);
        {HOST_TO_CARD_DMA_IDLE, CARD_TO_HOST_DMA_IDLE} = 2'($urandom);
        repeat (10) @(posedge SYS_CLK);
        RST_N <= 1;
        rd(CFCS_OFF_STATUS, {8'h0, HOST_TO_CARD_DMA_IDLE, CARD_TO_HOST_DMA_IDLE, 22'h30_0013}, 32'h00F0_00FF);
        // parameters loaded before init is requested
        @(posedge SYS_CLK) RX_MEMORY_SECTION <= $urandom;
        wr(CFCS_OFF_CONTROL, 32'h3);
        `CHK("sm reset", 1'b1, SM_RESET)
        `CHK("rx valid", 1'b0, RX_RVALID)
        wr(CFCS_OFF_CONTROL, 32'h0);
        wr(CFCS_OFF_CONTROL, 32'h1_0000);
        rd(CFCS_OFF_CONTROL, 32'h1_0000, 32'h1_0000);
        repeat (INIT_N + 8) @(posedge SYS_CLK);
        rd(CFCS_OFF_CONTROL, 32'h0, 32'h1_0000);
        `CHK("init params", RX_MEMORY_SECTION, MEM_INIT_PARAMS)
        wr(CFCS_OFF_CONTROL, 32'h1_0000);
        rd(CFCS_OFF_CONTROL, 32'h0, 32'h1_0000);
        for (int i = 0; i < 4; i++) begin
            w = $urandom & 32'hFFFE_FFFC;
            wr(CFCS_OFF_CONTROL, w);
            rd(CFCS_OFF_CONTROL, w & CTL_WRITE_MASK, 32'hFFFF_FFFF);
        end
        rd(4'h8, 32'h0, 32'hFFFF_FFFF);
        wr(CFCS_OFF_CONTROL, 32'h60);
        for (int i = 0; i < 7; i++) begin
            @(posedge SYS_CLK) ev[i] <= 1;
            @(posedge SYS_CLK) ev <= 7'h0;
            rd(CFCS_OFF_STATUS, 32'hFFFF_FFFF, 32'h1 << bp[i]);
            `CHK("dma irq", i < 2, HOST_IRQ)
            wr(CFCS_OFF_STATUS, 32'h1 << bp[i]);
            rd(CFCS_OFF_STATUS, 32'h0, 32'h1 << bp[i]);
        end
        wr(CFCS_OFF_CONTROL, 32'h10);
        `CHK("force no enable", 1'b0, HOST_IRQ)
        wr(CFCS_OFF_CONTROL, 32'h80);
        `CHK("tx boost", 1'b1, TX_DMA_PRIORITY_BOOST)
        wr(CFCS_OFF_CONTROL, 32'h0);
        @(posedge SYS_CLK) begin TX_FUNC_EN <= 1; RX_FUNC_EN <= 1; end
        traffic(6);
        @(posedge SYS_CLK) begin TX_FUNC_EN <= 0; RX_FUNC_EN <= 0; RX_HIGH_LEVEL <= 24'h0; end
        wr(CFCS_OFF_CONTROL, 32'h6_0104);
        traffic(6);
        repeat (4) @(posedge SYS_CLK);
        end_of_test();
    end
endmodule : cfcs_channel_bench
